// ### inc/pcmsr_consts.svh
/*
 Register indices, field positions, reset values and bus map constants
 of the configuration register bank.
 Assumes inclusion by the design files of this block only, the slave and the top.
*/
// Function
// - Power-on config bit reports bus reinit observation enable, 1 enabled.
// - Read-only bit gives in-order queue depth, 1 means one, 0 eight.
// - Read-only bit selects reset vector, 1 below 1 MB, 0 below 4 GB.
// - Read-only bit shows redundancy check mode, 1 enabled, 0 disabled.
// - Read-only two-bit field holds interrupt controller cluster id.
// - Read-only two-bit bus frequency field: 00 66, 10 100, 01 133 MHz.
// - Read-only two-bit field holds symmetric bus arbitration id.
// - Read-only four-bit field holds core to bus clock ratio.
// - Low power mode enable bit is software writable and readable.
// - Diagnostic control holds streaming buffer disable and lock suppress.
// - Patch load trigger sits at its own dedicated register index.
// - Three 64-bit chunk data registers at consecutive indices, read/write.
// - One 64-bit register serves as patch signature or chunk 3 data.
`ifndef PCMSR_CONSTS_SVH
`define PCMSR_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------------
`define PCMSR_IDX_PWR 8'h2A
`define PCMSR_IDX_DIAG 8'h33
`define PCMSR_IDX_TRIG 8'h79
`define PCMSR_IDX_CH0 8'h88
`define PCMSR_IDX_CH1 8'h89
`define PCMSR_IDX_CH2 8'h8A
`define PCMSR_IDX_CH3 8'h8B
`define PCMSR_IDX_CTR0 8'hC1
`define PCMSR_IDX_CTR1 8'hC2

// ----------------------------------------------------------------------
// Bus map: index in haddr[9:2], upper word select, out-of-map bit
// ----------------------------------------------------------------------
`define PCMSR_ADDR_IDX_MSB 9
`define PCMSR_ADDR_IDX_LSB 2
`define PCMSR_ADDR_HI_BIT 10
`define PCMSR_ADDR_OUT_BIT 11

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PCMSR_PWR_STRAP_LSB 12
`define PCMSR_PWR_OBS_BIT 12
`define PCMSR_PWR_IOQ_BIT 13
`define PCMSR_PWR_VEC_BIT 14
`define PCMSR_PWR_FRC_BIT 15
`define PCMSR_PWR_LP_BIT 26
`define PCMSR_DIAG_SBD_BIT 30
`define PCMSR_DIAG_LCK_BIT 31

// ----------------------------------------------------------------------
// Reset values and strap timing
// ----------------------------------------------------------------------
`define PCMSR_RST_LP 1'b0
`define PCMSR_RST_DIAG 2'b00
`define PCMSR_RST_DATA 64'h0000000000000000
`define PCMSR_RST_STRAP 14'h0000
`define PCMSR_STRAP_WAIT 2'h2

`endif

// ### inc/pcmsr_pkg.sv
/*
 Types shared by the register bank and its bus slave.
 Assumes the constants header is on the include path.
*/
package pcmsr_pkg;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef logic [63:0] pcmsr_reg_t;
    typedef logic [7:0] pcmsr_idx_t;
    typedef logic [13:0] pcmsr_strap_t;

    typedef enum logic [2:0]
    {
        PCMSR_ST_IDLE = 3'b001,
        PCMSR_ST_ACC = 3'b010,
        PCMSR_ST_RESP = 3'b100
    } pcmsr_state_e;

endpackage

// ### inc/pcmsr_if.sv
/*
 Internal access channel between the bus slave and the register bank.
 Assumes both ends run on the same system clock.
*/
`timescale 1ns/10ps
interface pcmsr_if;
    import pcmsr_pkg::*;

    logic wr_stb;
    logic rd_stb;
    pcmsr_idx_t idx;
    logic hi;
    logic [31:0] wdata;
    logic [31:0] rdata;

    modport slave
    (
        output wr_stb,
        output rd_stb,
        output idx,
        output hi,
        output wdata,
        input rdata
    );

    modport bank
    (
        input wr_stb,
        input rd_stb,
        input idx,
        input hi,
        input wdata,
        output rdata
    );
endinterface

// ### hdl/pcmsr_ahb_slave.sv
/*
 AHB-Lite slave front end: takes single word transfers, inserts one
 wait state, issues one-cycle access strobes to the bank.
 Assumes one master, word transfers, and the bank answering rdata
 combinationally in the strobe cycle.
*/
`timescale 1ns/10ps
`include "pcmsr_consts.svh"
module pcmsr_ahb_slave
    import pcmsr_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    pcmsr_if.slave bus
);

    pcmsr_state_e st_q, st_d;
    pcmsr_idx_t idx_q, idx_d;
    logic hi_q, hi_d;
    logic wr_q, wr_d;
    logic map_q, map_d;
    logic [31:0] rdata_q, rdata_d;
    logic take;

    // Address phase accepted on NONSEQ or SEQ with the bus ready
    assign take = hsel_in && htrans_in[1] && hready_in;

    // Transfer sequencing and address capture
    always_comb
    begin
        st_d = st_q;
        idx_d = idx_q;
        hi_d = hi_q;
        wr_d = wr_q;
        map_d = map_q;
        rdata_d = rdata_q;
        case (st_q)
            PCMSR_ST_IDLE, PCMSR_ST_RESP:
            begin
                st_d = take ? PCMSR_ST_ACC : PCMSR_ST_IDLE;
                if (take)
                begin
                    idx_d = haddr_in[`PCMSR_ADDR_IDX_MSB:`PCMSR_ADDR_IDX_LSB];
                    hi_d = haddr_in[`PCMSR_ADDR_HI_BIT];
                    wr_d = hwrite_in;
                    map_d = !haddr_in[`PCMSR_ADDR_OUT_BIT];
                end
            end
            PCMSR_ST_ACC:
            begin
                st_d = PCMSR_ST_RESP;
                rdata_d = (!wr_q && map_q) ? bus.rdata : 32'h00000000;
            end
            default:
                st_d = PCMSR_ST_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            st_q <= PCMSR_ST_IDLE;
            idx_q <= 8'h00;
            hi_q <= 1'b0;
            wr_q <= 1'b0;
            map_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            st_q <= st_d;
            idx_q <= idx_d;
            hi_q <= hi_d;
            wr_q <= wr_d;
            map_q <= map_d;
            rdata_q <= rdata_d;
        end
    end

    // Strobes to the bank in the wait-state cycle
    assign bus.wr_stb = (st_q == PCMSR_ST_ACC) && wr_q && map_q;
    assign bus.rd_stb = (st_q == PCMSR_ST_ACC) && !wr_q && map_q;
    assign bus.idx = idx_q;
    assign bus.hi = hi_q;
    assign bus.wdata = hwdata_in;
    assign hreadyout_out = (st_q != PCMSR_ST_ACC);
    assign hrdata_out = rdata_q;
endmodule

// ### hdl/pcmsr_top.sv
/*
 Configuration register bank: power-on configuration with strap fields,
 diagnostic control, patch load trigger, cache chunk data and event
 counter storage, reached over AHB-Lite.
 Assumes strap pins are static after reset and come from outside the
 clock domain.
*/
`timescale 1ns/10ps
`include "pcmsr_consts.svh"
module pcmsr_top
    import pcmsr_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic bus_reinit_obs_in,
    input wire logic ioq_depth_one_in,
    input wire logic low_vector_in,
    input wire logic redundancy_check_mode_in,
    input wire logic [1:0] cluster_id_in,
    input wire logic [1:0] bus_freq_in,
    input wire logic [1:0] arb_id_in,
    input wire logic [3:0] clk_ratio_in,
    output logic low_power_en_out,
    output logic stream_buf_dis_out,
    output logic lock_suppress_out,
    output logic patch_load_pulse_out
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Replace one 32-bit half of a 64-bit register
    function automatic pcmsr_reg_t pcmsr_merge(
        input pcmsr_reg_t old,
        input logic hi,
        input logic [31:0] wd
    );
        pcmsr_merge = hi ? {wd, old[31:0]} : {old[63:32], wd};
    endfunction

    // Select one 32-bit half of a 64-bit register
    function automatic logic [31:0] pcmsr_half(
        input pcmsr_reg_t v,
        input logic hi
    );
        pcmsr_half = hi ? v[63:32] : v[31:0];
    endfunction

    // ------------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------------
    pcmsr_if bus();

    pcmsr_ahb_slave u_slave
    (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .hsel_in(hsel_in),
        .haddr_in(haddr_in),
        .htrans_in(htrans_in),
        .hwrite_in(hwrite_in),
        .hwdata_in(hwdata_in),
        .hready_in(hready_in),
        .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out),
        .bus(bus.slave)
    );

    // Only word transfers are expected; response is always OKAY
    assign hresp_out = 1'b0;

    // ------------------------------------------------------------------
    // Strap synchronisation and capture
    // ------------------------------------------------------------------
    pcmsr_strap_t strap_raw;
    pcmsr_strap_t sync1_q, sync2_q;
    pcmsr_strap_t cfg_q, cfg_d;
    logic [1:0] wait_q, wait_d;
    logic done_q, done_d;

    // Pin order matches the field order of the config register
    assign strap_raw = {clk_ratio_in, arb_id_in, bus_freq_in,
                        cluster_id_in, redundancy_check_mode_in,
                        low_vector_in, ioq_depth_one_in, bus_reinit_obs_in};

    // Two-flop synchroniser on the strap pins
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            sync1_q <= `PCMSR_RST_STRAP;
            sync2_q <= `PCMSR_RST_STRAP;
        end
        else
        begin
            sync1_q <= strap_raw;
            sync2_q <= sync1_q;
        end
    end

    // Capture straps once the synchroniser has filled after release
    always_comb
    begin
        wait_d = wait_q;
        cfg_d = cfg_q;
        done_d = done_q;
        if (!done_q)
        begin
            if (wait_q == `PCMSR_STRAP_WAIT)
            begin
                cfg_d = sync2_q;
                done_d = 1'b1;
            end
            else
            begin
                wait_d = wait_q + 2'h1;
            end
        end
    end

    // Strap capture registers
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            wait_q <= 2'h0;
            cfg_q <= `PCMSR_RST_STRAP;
            done_q <= 1'b0;
        end
        else
        begin
            wait_q <= wait_d;
            cfg_q <= cfg_d;
            done_q <= done_d;
        end
    end

    // ------------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------------
    logic lp_q, lp_d;
    logic [1:0] diag_q, diag_d;
    logic pulse_q, pulse_d;
    pcmsr_reg_t chunk_q [0:3];
    pcmsr_reg_t chunk_d [0:3];
    pcmsr_reg_t ctr_q [0:1];
    pcmsr_reg_t ctr_d [0:1];
    logic wr_lo;

    assign wr_lo = bus.wr_stb && !bus.hi;

    // Register updates on write strobes
    always_comb
    begin
        lp_d = lp_q;
        diag_d = diag_q;
        pulse_d = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            chunk_d[i] = chunk_q[i];
        end
        for (int i = 0; i < 2; i++)
        begin
            ctr_d[i] = ctr_q[i];
        end
        if (bus.wr_stb)
        begin
            case (bus.idx)
                `PCMSR_IDX_PWR:
                    lp_d = wr_lo ? bus.wdata[`PCMSR_PWR_LP_BIT]
                        : lp_q;
                `PCMSR_IDX_DIAG:
                    diag_d = wr_lo ?
                        bus.wdata[`PCMSR_DIAG_LCK_BIT:`PCMSR_DIAG_SBD_BIT]
                        : diag_q;
                `PCMSR_IDX_TRIG:
                    pulse_d = 1'b1;
                `PCMSR_IDX_CH0, `PCMSR_IDX_CH1, `PCMSR_IDX_CH2:
                    chunk_d[bus.idx[1:0]] = pcmsr_merge(
                        chunk_q[bus.idx[1:0]], bus.hi, bus.wdata);
                `PCMSR_IDX_CH3:
                    chunk_d[3] = pcmsr_merge(chunk_q[3], bus.hi,
                        bus.wdata);
                `PCMSR_IDX_CTR0:
                    ctr_d[0] = pcmsr_merge(ctr_q[0], bus.hi, bus.wdata);
                `PCMSR_IDX_CTR1:
                    ctr_d[1] = pcmsr_merge(ctr_q[1], bus.hi, bus.wdata);
                default:
                    pulse_d = 1'b0;
            endcase
        end
    end

    // Writable state registers
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            lp_q <= `PCMSR_RST_LP;
            diag_q <= `PCMSR_RST_DIAG;
            pulse_q <= 1'b0;
            for (int i = 0; i < 4; i++)
            begin
                chunk_q[i] <= `PCMSR_RST_DATA;
            end
            for (int i = 0; i < 2; i++)
            begin
                ctr_q[i] <= `PCMSR_RST_DATA;
            end
        end
        else
        begin
            lp_q <= lp_d;
            diag_q <= diag_d;
            pulse_q <= pulse_d;
            for (int i = 0; i < 4; i++)
            begin
                chunk_q[i] <= chunk_d[i];
            end
            for (int i = 0; i < 2; i++)
            begin
                ctr_q[i] <= ctr_d[i];
            end
        end
    end

    assign low_power_en_out = lp_q;
    assign stream_buf_dis_out = diag_q[0];
    assign lock_suppress_out = diag_q[1];
    assign patch_load_pulse_out = pulse_q;

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    pcmsr_reg_t pwr_val;
    pcmsr_reg_t diag_val;

    // Strap fields at 25:12, low power at 26, rest reads zero
    assign pwr_val = {37'h0, lp_q, cfg_q,
                      12'h000};
    assign diag_val = {32'h00000000, diag_q, 30'h00000000};

    // Trigger is write only and reads zero
    always_comb
    begin
        case (bus.idx)
            `PCMSR_IDX_PWR: bus.rdata = pcmsr_half(pwr_val, bus.hi);
            `PCMSR_IDX_DIAG: bus.rdata = pcmsr_half(diag_val, bus.hi);
            `PCMSR_IDX_CH0, `PCMSR_IDX_CH1, `PCMSR_IDX_CH2, `PCMSR_IDX_CH3:
                bus.rdata = pcmsr_half(chunk_q[bus.idx[1:0]], bus.hi);
            `PCMSR_IDX_CTR0: bus.rdata = pcmsr_half(ctr_q[0], bus.hi);
            `PCMSR_IDX_CTR1: bus.rdata = pcmsr_half(ctr_q[1], bus.hi);
            default: bus.rdata = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);

    // Low-word config read once straps are captured and stable
    sequence s_pwr_rd;
        bus.rd_stb && done_q && bus.idx == `PCMSR_IDX_PWR && !bus.hi;
    endsequence

    // Low-word write to a given index
    sequence s_wr_lo(logic [7:0] ix);
        wr_lo && bus.idx == ix;
    endsequence

    pwr_obs_bit_a: assert property (
        s_pwr_rd |=> hrdata_out[`PCMSR_PWR_OBS_BIT] == cfg_q[0])
        else $error("reinit observation bit wrong");
    ioq_depth_bit_a: assert property (
        s_pwr_rd |=> hrdata_out[`PCMSR_PWR_IOQ_BIT] == cfg_q[1])
        else $error("queue depth bit wrong");
    reset_vector_bit_a: assert property (
        s_pwr_rd |=> hrdata_out[`PCMSR_PWR_VEC_BIT] == cfg_q[2])
        else $error("reset vector bit wrong");
    redundancy_mode_bit_a: assert property (
        s_pwr_rd |=> hrdata_out[`PCMSR_PWR_FRC_BIT] == cfg_q[3])
        else $error("redundancy mode bit wrong");
    cluster_field_a: assert property (
        s_pwr_rd |=> hrdata_out[17:16] == cfg_q[5:4])
        else $error("cluster field wrong");
    bus_freq_field_a: assert property (
        s_pwr_rd |=> hrdata_out[19:18] == cfg_q[7:6])
        else $error("bus frequency field wrong");
    arb_id_field_a: assert property (
        s_pwr_rd |=> hrdata_out[21:20] == cfg_q[9:8])
        else $error("arbitration field wrong");
    clk_ratio_field_a: assert property (
        s_pwr_rd |=> hrdata_out[25:22] == cfg_q[13:10] &&
        hrdata_out[31:26] == {5'h00, lp_q} && hrdata_out[11:0] == 12'h000)
        else $error("clock ratio field or reserved bits wrong");
    low_power_wr_a: assert property (
        s_wr_lo(`PCMSR_IDX_PWR) |=>
        low_power_en_out == $past(bus.wdata[`PCMSR_PWR_LP_BIT]))
        else $error("low power enable not written");
    diag_bits_wr_a: assert property (
        s_wr_lo(`PCMSR_IDX_DIAG) |=>
        {lock_suppress_out, stream_buf_dis_out} == $past(bus.wdata[31:30]))
        else $error("diagnostic bits not written");
    trig_pulse_a: assert property (
        bus.wr_stb && bus.idx == `PCMSR_IDX_TRIG |=>
        patch_load_pulse_out ##1 !patch_load_pulse_out)
        else $error("trigger pulse wrong");
    chunk_store_a: assert property (
        bus.wr_stb && bus.idx >= `PCMSR_IDX_CH0 &&
        bus.idx <= `PCMSR_IDX_CH2 |=>
        pcmsr_half(chunk_q[$past(bus.idx[1:0])], $past(bus.hi))
        == $past(bus.wdata))
        else $error("chunk data not stored");
    chunk3_store_a: assert property (
        bus.wr_stb && bus.idx == `PCMSR_IDX_CH3 |=>
        pcmsr_half(chunk_q[3], $past(bus.hi)) == $past(bus.wdata))
        else $error("signature register store wrong");
endmodule

// ### testbench/testbench.sv
/*
 Self-checking bench for the configuration register bank: AHB-Lite
 master tasks, strap capture, writable bits, trigger pulse and storage.
 Assumes hready is looped back from the slave and no other master.
*/
`timescale 1ns/10ps
module testbench
    import pcmsr_pkg::*;
;
    logic clk_sys_in, nrst_in, hsel_in, hwrite_in;
    logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
    logic [1:0] htrans_in, cluster_in, freq_in, arb_in;
    logic [2:0] hsize_in;
    logic [3:0] ratio_in;
    logic hreadyout_out, hresp_out, obs_in, ioq_in, vec_in, frc_in;
    logic low_power_en_out, stream_buf_dis_out, lock_suppress_out;
    logic patch_load_pulse_out, pulse_seen;
    logic [7:0] idx_tab [6] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'hC1, 8'hC2};
    logic [31:0] diag_tab [4] = '{32'hFFFFFFFF, 32'h40000000,
                                  32'h80000000, 32'h00000000};
    int err_total, n_compared;

    pcmsr_top pcmsr_top_i
    (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .hsel_in(hsel_in),
        .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
        .hsize_in(hsize_in), .hwdata_in(hwdata_in),
        .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
        .bus_reinit_obs_in(obs_in), .ioq_depth_one_in(ioq_in),
        .low_vector_in(vec_in), .redundancy_check_mode_in(frc_in),
        .cluster_id_in(cluster_in), .bus_freq_in(freq_in),
        .arb_id_in(arb_in), .clk_ratio_in(ratio_in),
        .low_power_en_out(low_power_en_out),
        .stream_buf_dis_out(stream_buf_dis_out),
        .lock_suppress_out(lock_suppress_out),
        .patch_load_pulse_out(patch_load_pulse_out)
    );

    // ------------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------------
    initial
    begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end

    // Whole run needs well under 1000 cycles
    initial
    begin
        #200000;
        err_total++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        report_and_stop();
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("Counts: %0d compared, %0d mismatched", n_compared,
                 err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time,
                     what, seen, exp);
        end
    endtask

    // One single AHB transfer, waits on hready with a bound
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        hsel_in <= 1'b1;
        htrans_in <= 2'b10;
        haddr_in <= a;
        hwrite_in <= wr;
        hsize_in <= 3'b010;
        @(posedge clk_sys_in);
        while (hreadyout_out !== 1'b1 && n < 20)
        begin
            @(posedge clk_sys_in);
            n++;
        end
        htrans_in <= 2'b00;
        hwdata_in <= wd;
        @(posedge clk_sys_in);
        while (hreadyout_out !== 1'b1 && n < 20)
        begin
            @(posedge clk_sys_in);
            n++;
        end
        rd = hrdata_out;
        pulse_seen = patch_load_pulse_out;
        if (n >= 20)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: no ready from slave", $time);
        end
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp,
                         input string what);
        bus(1'b0, a, 32'h00000000);
        check(rd, exp, what);
    endtask

    // Strap pattern from a two-bit seed, fields by bit position
    function automatic logic [31:0] strap_word(input logic [1:0] b);
        logic [31:0] w;
        w = 32'h00000000;
        w[12] = b[0];
        w[13] = ~b[0];
        w[14] = b[1];
        w[15] = ~b[1];
        w[17:16] = b;
        w[19:18] = b;
        w[21:20] = ~b;
        w[25:22] = {b, ~b};
        return w;
    endfunction

    task automatic set_straps(input logic [1:0] b);
        {obs_in, ioq_in, vec_in, frc_in} <= {b[0], ~b[0], b[1], ~b[1]};
        {cluster_in, freq_in, arb_in, ratio_in} <= {b, b, ~b, b, ~b};
    endtask

    task automatic do_reset();
        nrst_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        repeat (5) @(posedge clk_sys_in);
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial
    begin
        nrst_in = 1'b0;
        {hsel_in, hwrite_in, htrans_in, haddr_in, hwdata_in} = '0;
        hsize_in = 3'b010;
        {obs_in, ioq_in, vec_in, frc_in} = 4'h0;
        {cluster_in, freq_in, arb_in, ratio_in} = 10'h000;
        err_total = 0;
        n_compared = 0;
        repeat (3) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        repeat (5) @(posedge clk_sys_in);
        check({29'h0, low_power_en_out, stream_buf_dis_out,
               lock_suppress_out}, 32'h0, "reset outputs");
        rdchk(32'h000000CC, 32'h0, "diag reset");
        $display("Test reset values done");

        // Every bus frequency code, strap changes after capture ignored
        for (int i = 0; i < 4; i++)
        begin
            set_straps(2'(i));
            do_reset();
            rdchk(32'h000000A8, strap_word(2'(i)),
                  "straps");
            set_straps(2'(3 - i));
            rdchk(32'h000000A8, strap_word(2'(i)), "held");
            rdchk(32'h000004A8, 32'h0, "config upper");
        end
        $display("Test strap fields done");

        bus(1'b1, 32'h000000A8, 32'hFFFFFFFF);
        check({31'h0, hresp_out}, 32'h0, "okay response");
        check({31'h0, pulse_seen}, 32'h0, "no trigger on config");
        check({31'h0, low_power_en_out}, 32'h1, "low power on");
        rdchk(32'h000000A8, strap_word(2'd3) | 32'h04000000,
              "lp set");
        bus(1'b1, 32'h000004A8, 32'hFFFFFFFF);
        rdchk(32'h000004A8, 32'h0, "config upper ro");
        bus(1'b1, 32'h000000A8, 32'h00000000);
        check({31'h0, low_power_en_out}, 32'h0, "low power off");
        rdchk(32'h000000A8, strap_word(2'd3), "lp clear");
        $display("Test low power bit done");

        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, 32'h000000CC, diag_tab[i]);
            check({30'h0, lock_suppress_out, stream_buf_dis_out},
                  {30'h0, diag_tab[i][31:30]}, "diag outputs");
            rdchk(32'h000000CC, diag_tab[i] & 32'hC0000000, "diag");
        end
        bus(1'b1, 32'h000004CC, 32'hFFFFFFFF);
        check({30'h0, lock_suppress_out, stream_buf_dis_out}, 32'h0,
              "diag upper no effect");
        $display("Test diagnostic control done");

        for (int h = 0; h < 2; h++)
        begin
            bus(1'b1, 32'h000001E4 | (32'(h) << 10), 32'h00000000);
            check({31'h0, pulse_seen}, 32'h1, "trigger pulse");
            @(posedge clk_sys_in);
            check({31'h0, patch_load_pulse_out}, 32'h0, "pulse off");
            rdchk(32'h000001E4 | (32'(h) << 10), 32'h0,
                  "trigger read");
        end
        $display("Test patch trigger done");

        for (int k = 0; k < 6; k++)
        begin
            bus(1'b1, {22'h0, idx_tab[k], 2'b00}, 32'h5A5A0000 + 32'(k));
            bus(1'b1, {21'h0, 1'b1, idx_tab[k], 2'b00},
                32'hC3C30000 + 32'(k));
        end
        for (int k = 0; k < 6; k++)
        begin
            rdchk({22'h0, idx_tab[k], 2'b00}, 32'h5A5A0000 + 32'(k),
                  "lo");
            rdchk({21'h0, 1'b1, idx_tab[k], 2'b00}, 32'hC3C30000 + 32'(k),
                  "hi");
        end
        $display("Test chunk and counter storage done");

        bus(1'b1, 32'h00000A20, 32'hFFFFFFFF);
        rdchk(32'h00000A20, 32'h0, "out of map");
        bus(1'b1, 32'h00000100, 32'hFFFFFFFF);
        rdchk(32'h00000100, 32'h0, "unmapped index");
        rdchk(32'h00000220, 32'h5A5A0000, "chunk0 intact");
        $display("Test unmapped access done");
        report_and_stop();
    end
endmodule
